// ### design/rsm_pkg.sv
/*
  rsm_pkg: constants for the reset, strap and miscellaneous pin block.
  assumes a 50 MHz core clock and a plain strobe register port.
*/
package rsm_pkg;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int REF_HZ = 25_000_000;
  localparam int POR_US = 100;
  localparam int POR_CYC = (POR_US * (CLK_HZ / 1_000_000));
  localparam int FBRST_US = 10;
  localparam int FBRST_CYC = (FBRST_US * (CLK_HZ / 1_000_000));
  localparam int PIN_RST_MIN_CYC = 2;
  localparam int STRAP_W = 8;
  // register offsets (byte addresses)
  localparam logic [7:0] ADR_IRQ_CFG = 8'h00;
  localparam logic [7:0] ADR_WAKE_CFG = 8'h04;
  localparam logic [7:0] ADR_STRAP = 8'h08;
  localparam logic [7:0] ADR_INT_STS = 8'h0C;
  localparam logic [7:0] ADR_INT_EN = 8'h10;
  localparam logic [7:0] ADR_INT_CLR = 8'h14;
  localparam logic [7:0] ADR_FB_RESET = 8'h18;
  localparam logic [7:0] ADR_EVENT = 8'h1C;
  // irq cfg fields
  localparam int IRQ_POL_BIT = 0;
  localparam int IRQ_OD_BIT = 1;
  localparam int IRQ_SRC_LSB = 4;
  localparam int IRQ_SRC_W = 2;
  // wake cfg fields
  localparam int WK_EN_BIT = 0;
  localparam int WK_POL_BIT = 1;
  localparam int WK_OD_BIT = 2;
  localparam int WK_MAP_LSB = 4;
  localparam int WK_MAP_W = 2;
  // status event bits
  localparam int EV_W = 4;
  localparam int EV_WAKE = 0;
  localparam int EV_PIN_RST = 1;
  localparam int EV_EEP_ERR = 2;
  localparam int EV_HOST = 3;
  // fieldbus reset key, written to ADR_FB_RESET three times in order
  localparam logic [7:0] FB_KEY0 = 8'h52;
  localparam logic [7:0] FB_KEY1 = 8'h45;
  localparam logic [7:0] FB_KEY2 = 8'h53;
  // wake mapping codes
  localparam logic [1:0] MAP_DED = 2'h0;
  localparam logic [1:0] MAP_ERR = 2'h1;
  localparam logic [1:0] MAP_GPIO = 2'h2;
  // clock strap levels (comparator code from the three-level pad)
  typedef enum logic [1:0] {
    OSC_LOW = 2'h0,
    OSC_MID = 2'h1,
    OSC_HIGH = 2'h3
  } rsm_osc_lvl_t;
endpackage

// ### design/rsm_sync.sv
/*
  rsm_sync: two flip-flop synchroniser for a vector of pin levels.
  assumes inputs are quasi-static or slow compared to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rsm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ### design/rsm_strap.sv
/*
  rsm_strap: strap latch, holds the captured straps until the next capture.
  assumes capture is a one-cycle pulse on already synchronised straps.
*/
`timescale 1ns/1ps
`default_nettype none
module rsm_strap
  import rsm_pkg::*;
#(
  parameter int W = STRAP_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // capture
  input wire logic capture,
  input wire logic [W-1:0] strap_in,
  input wire logic [1:0] osc_lvl_in,
  // held values
  output logic [W-1:0] strap_q,
  output logic [1:0] osc_lvl_q
);
  logic [W-1:0] next_strap_q;
  logic [1:0] next_osc_lvl_q;
  always_comb begin
    next_strap_q = strap_q;
    next_osc_lvl_q = osc_lvl_q;
    if (capture) begin // [R1] [R13]
      next_strap_q = strap_in;
      next_osc_lvl_q = osc_lvl_in;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_q <= '0;
      osc_lvl_q <= OSC_LOW;
    end else begin
      strap_q <= next_strap_q;
      osc_lvl_q <= next_osc_lvl_q;
    end
  end
endmodule
`default_nettype wire

// ### design/rsm_top.sv
/*
  rsm_top: reset handling, strap capture, host interrupt, wake output and
  clock strap decode of the slave controller.
  assumes RST_N is the on-chip power-on reset, register strobes come from
  logic on REF_CLK, and all pin inputs are asynchronous to REF_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: straps captured at power-on, fieldbus reset and external reset release
// R2: host irq polarity, source and push-pull/open-drain set by register
// R3: wake output asserts on a wake event when enabled
// R4: wake output polarity and drive type set by register
// R5: wake output optionally enabled and mapped onto one of several pins
// R6: wake on error pin plus eeprom load failure forces error indicator on
// R7: low on system reset pin resets the device
// R8: internal power-on reset, external pin may float
// R9: reset pin driven low during power-on and fieldbus reset sequence
// R10: runs from a 25 MHz crystal or oscillator reference
// R11: three-level clock strap selects clock out and oscillator input mode
// R12: board straps schmitt mode when daisy-chained from another device
// R13: captured straps stay fixed until next reset and set defaults
module rsm_top
  import rsm_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC,
  parameter int FBRST_CYCLES = FBRST_CYC
) (
  // clock and power-on reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // system reset pin, open drain
  input wire logic SYS_RST_PIN_IN,
  output logic SYS_RST_PIN_OUT,
  output logic SYS_RST_PIN_OE,
  output logic CORE_RST_N,
  // strap pins and three-level clock strap comparators
  input wire logic [STRAP_W-1:0] STRAP_PINS,
  input wire logic [1:0] OSC_INPUT_MODE_STRAP,
  output logic CLK_OUT_EN,
  output logic OSC_SCHMITT_SEL,
  // events from the core
  input wire logic WAKE_DETECT,
  input wire logic EEPROM_LOAD_ERR,
  input wire logic [IRQ_SRC_W-1:0] CORE_IRQ,
  // host interrupt pin
  output logic HOST_IRQ_OUT,
  output logic HOST_IRQ_OE,
  // wake event pins
  output logic WAKE_EVENT_OUT,
  output logic WAKE_EVENT_OE,
  output logic ERROR_INDICATOR_LED,
  output logic ERROR_INDICATOR_LED_OE,
  output logic WAKE_GPIO_OUT,
  output logic WAKE_GPIO_OE,
  output logic ERR_LED_FORCED
);
  // synchronised pins
  logic rst_pin_s;
  logic [STRAP_W-1:0] strap_s;
  logic [1:0] osc_s;
  logic wake_s;
  logic eep_s;
  // the pin is pulled low through reset, so the synchroniser starts low too
  rsm_sync #(.W(1), .INIT(1'b0)) u_sync_rst (
    .clk(REF_CLK), .rst_n(RST_N), .d(SYS_RST_PIN_IN), .q(rst_pin_s)
  ); // [R7]
  rsm_sync #(.W(STRAP_W + 4), .INIT('0)) u_sync_misc (
    .clk(REF_CLK), .rst_n(RST_N),
    .d({STRAP_PINS, OSC_INPUT_MODE_STRAP, WAKE_DETECT, EEPROM_LOAD_ERR}),
    .q({strap_s, osc_s, wake_s, eep_s})
  );

  // reset sequencer state
  typedef enum logic [3:0] {
    ST_POR = 4'b0001,
    ST_RUN = 4'b0010,
    ST_FBRST = 4'b0100,
    ST_PINRST = 4'b1000
  } rsm_state_t;
  rsm_state_t state;
  rsm_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [1:0] key_idx;
  logic [1:0] next_key_idx;
  logic capture;
  logic fb_seq_done;

  // fieldbus reset command: three key bytes in order, any miss restarts
  always_comb begin
    next_key_idx = key_idx;
    fb_seq_done = 1'b0;
    if (WR && ADDR == ADR_FB_RESET) begin
      unique case (key_idx)
        2'd0: next_key_idx = (WDATA[7:0] == FB_KEY0) ? 2'd1 : 2'd0;
        2'd1: next_key_idx = (WDATA[7:0] == FB_KEY1) ? 2'd2 : 2'd0;
        default: begin
          next_key_idx = 2'd0;
          fb_seq_done = (WDATA[7:0] == FB_KEY2); // [R9]
        end
      endcase
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    capture = 1'b0;
    unique case (state)
      ST_POR: begin // [R8]
        next_cnt = cnt + 32'd1;
        if (cnt >= 32'(POR_CYCLES - 1)) begin
          // own pull still reads low through the synchroniser: wait it out
          next_state = ST_PINRST;
          next_cnt = '0;
        end
      end
      ST_RUN: begin
        if (!rst_pin_s) begin
          next_state = ST_PINRST; // [R7]
        end else if (fb_seq_done) begin
          next_state = ST_FBRST;
          next_cnt = '0;
        end
      end
      ST_FBRST: begin // [R9]
        next_cnt = cnt + 32'd1;
        if (cnt >= 32'(FBRST_CYCLES - 1)) begin
          next_state = ST_PINRST;
          next_cnt = '0;
        end
      end
      ST_PINRST: begin
        // waits for the pin to read high again, own drive released
        if (rst_pin_s) begin
          next_state = ST_RUN;
          capture = 1'b1; // [R1]
        end
      end
      default: next_state = ST_POR;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_POR;
      cnt <= '0;
      key_idx <= 2'd0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      key_idx <= next_key_idx;
    end
  end

  // straps
  logic [STRAP_W-1:0] strap_q;
  logic [1:0] osc_q;
  rsm_strap #(.W(STRAP_W)) u_strap (
    .clk(REF_CLK), .rst_n(RST_N), .capture(capture),
    .strap_in(strap_s), .osc_lvl_in(osc_s),
    .strap_q(strap_q), .osc_lvl_q(osc_q)
  );

  // configuration and interrupt registers
  logic [7:0] irq_cfg;
  logic [7:0] wake_cfg;
  logic [EV_W-1:0] int_sts;
  logic [EV_W-1:0] int_en;
  logic [7:0] next_irq_cfg;
  logic [7:0] next_wake_cfg;
  logic [EV_W-1:0] next_int_sts;
  logic [EV_W-1:0] next_int_en;
  logic [31:0] next_rdata;
  logic [EV_W-1:0] ev;
  logic wake_d;
  logic eep_d;
  logic rst_pin_d;
  logic in_reset;

  assign in_reset = (state != ST_RUN);

  always_comb begin
    ev = '0;
    ev[EV_WAKE] = wake_s && !wake_d;
    ev[EV_PIN_RST] = !rst_pin_s && rst_pin_d;
    ev[EV_EEP_ERR] = eep_s && !eep_d;
    ev[EV_HOST] = WR && ADDR == ADR_EVENT && WDATA[0];
    next_irq_cfg = irq_cfg;
    next_wake_cfg = wake_cfg;
    next_int_en = int_en;
    next_int_sts = int_sts;
    if (capture) begin
      // strap bits supply power-up defaults of the drive fields
      next_irq_cfg[IRQ_OD_BIT] = strap_s[0]; // [R13]
      next_wake_cfg[WK_OD_BIT] = strap_s[1]; // [R13]
    end
    if (WR && ADDR == ADR_IRQ_CFG) next_irq_cfg = WDATA[7:0]; // [R2]
    if (WR && ADDR == ADR_WAKE_CFG) next_wake_cfg = WDATA[7:0]; // [R4] [R5]
    if (WR && ADDR == ADR_INT_EN) next_int_en = WDATA[EV_W-1:0];
    if (WR && ADDR == ADR_INT_CLR) next_int_sts = int_sts & ~WDATA[EV_W-1:0];
    // set wins over a clear in the same cycle
    next_int_sts = next_int_sts | ev;
    next_rdata = '0;
    if (RD) begin
      unique case (ADDR)
        ADR_IRQ_CFG: next_rdata = {24'h00_0000, irq_cfg};
        ADR_WAKE_CFG: next_rdata = {24'h00_0000, wake_cfg};
        ADR_STRAP: next_rdata = {16'h0000, state, osc_q, 2'b00, strap_q}; // [R13]
        ADR_INT_STS: next_rdata = {28'h000_0000, int_sts};
        ADR_INT_EN: next_rdata = {28'h000_0000, int_en};
        default: next_rdata = '0;
      endcase
    end
  end

  // pin outputs
  logic irq_src;
  logic irq_act;
  logic wake_act;
  logic wake_lvl;
  logic err_force;
  logic next_err_force;
  logic [1:0] wmap;
  always_comb begin
    unique case (irq_cfg[IRQ_SRC_LSB +: IRQ_SRC_W])
      2'd0: irq_src = |(int_sts & int_en);
      2'd1: irq_src = CORE_IRQ[0];
      2'd2: irq_src = CORE_IRQ[1];
      default: irq_src = |(int_sts & int_en) | |CORE_IRQ;
    endcase
    irq_act = irq_src && !in_reset; // [R2]
    wmap = wake_cfg[WK_MAP_LSB +: WK_MAP_W];
    wake_act = wake_cfg[WK_EN_BIT] && int_sts[EV_WAKE]; // [R3]
    wake_lvl = wake_act ~^ wake_cfg[WK_POL_BIT]; // [R4]
    // failed eeprom load with wake on error pin: indicator forced on
    next_err_force = err_force || (wmap == MAP_ERR && eep_s); // [R6]
    if (capture) next_err_force = 1'b0;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_cfg <= 8'h00;
      wake_cfg <= 8'h00;
      int_sts <= '0;
      int_en <= '0;
      RDATA <= 32'h0000_0000;
      wake_d <= 1'b0;
      eep_d <= 1'b0;
      rst_pin_d <= 1'b0;
      err_force <= 1'b0;
      SYS_RST_PIN_OUT <= 1'b0;
      SYS_RST_PIN_OE <= 1'b1;
      CORE_RST_N <= 1'b0;
      CLK_OUT_EN <= 1'b0;
      OSC_SCHMITT_SEL <= 1'b0;
      HOST_IRQ_OUT <= 1'b0;
      HOST_IRQ_OE <= 1'b0;
      WAKE_EVENT_OUT <= 1'b0;
      WAKE_EVENT_OE <= 1'b0;
      ERROR_INDICATOR_LED <= 1'b0;
      ERROR_INDICATOR_LED_OE <= 1'b0;
      WAKE_GPIO_OUT <= 1'b0;
      WAKE_GPIO_OE <= 1'b0;
      ERR_LED_FORCED <= 1'b0;
    end else begin
      irq_cfg <= next_irq_cfg;
      wake_cfg <= next_wake_cfg;
      int_sts <= next_int_sts;
      int_en <= next_int_en;
      RDATA <= next_rdata;
      wake_d <= wake_s;
      eep_d <= eep_s;
      rst_pin_d <= rst_pin_s;
      err_force <= next_err_force;
      SYS_RST_PIN_OUT <= 1'b0;
      SYS_RST_PIN_OE <= (next_state == ST_POR) || (next_state == ST_FBRST); // [R9]
      CORE_RST_N <= (next_state == ST_RUN); // [R7]
      // strap level code: low off/crystal, mid on/crystal, high on/schmitt
      CLK_OUT_EN <= (osc_q != OSC_LOW); // [R11] [R10]
      OSC_SCHMITT_SEL <= (osc_q == OSC_HIGH); // [R11] [R12]
      // open drain drives only the active level, push-pull drives always
      HOST_IRQ_OUT <= irq_act ~^ irq_cfg[IRQ_POL_BIT];
      HOST_IRQ_OE <= !irq_cfg[IRQ_OD_BIT] || irq_act; // [R2]
      WAKE_EVENT_OUT <= wake_lvl;
      WAKE_EVENT_OE <= wake_cfg[WK_EN_BIT] && wmap == MAP_DED &&
                       (!wake_cfg[WK_OD_BIT] || wake_act); // [R5]
      ERROR_INDICATOR_LED <= next_err_force ? 1'b1 : wake_lvl;
      ERROR_INDICATOR_LED_OE <= next_err_force ||
        (wake_cfg[WK_EN_BIT] && wmap == MAP_ERR &&
         (!wake_cfg[WK_OD_BIT] || wake_act)); // [R6]
      WAKE_GPIO_OUT <= wake_lvl;
      WAKE_GPIO_OE <= wake_cfg[WK_EN_BIT] && wmap == MAP_GPIO &&
                      (!wake_cfg[WK_OD_BIT] || wake_act); // [R5]
      ERR_LED_FORCED <= next_err_force;
    end
  end
endmodule
`default_nettype wire

// ### tb/rsm_chk.sv
/*
  rsm_chk: port checker for rsm_top.
  assumes one clock and the async low power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rsm_chk
  import rsm_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC,
  parameter int FBRST_CYCLES = FBRST_CYC
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // register port
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // reset pin and core reset
  input wire logic SYS_RST_PIN_IN,
  input wire logic SYS_RST_PIN_OUT,
  input wire logic SYS_RST_PIN_OE,
  input wire logic CORE_RST_N,
  // clock strap and error indicator
  input wire logic CLK_OUT_EN,
  input wire logic OSC_SCHMITT_SEL,
  input wire logic EEPROM_LOAD_ERR,
  input wire logic ERR_LED_FORCED
);
  logic [15:0] cyc, next_cyc, run, next_run;
  logic arm, next_arm;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // saturate so a long run never wraps under the power-on count
  always_comb begin
    next_cyc = (cyc == 16'hFFFF) ? cyc : cyc + 16'h0001;
    next_run = SYS_RST_PIN_OE ? run + 16'h0001 : 16'h0000;
    // armed only when the pull starts from run state
    next_arm = SYS_RST_PIN_OE ? arm : CORE_RST_N;
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cyc <= 16'h0000;
      run <= 16'h0000;
      arm <= 1'b0;
    end else begin
      cyc <= next_cyc;
      run <= next_run;
      arm <= next_arm;
    end
  end
  sequence pin_held_low;
    !SYS_RST_PIN_IN [*4];
  endsequence
  sequence fb_pull_end;
    arm && $fell(SYS_RST_PIN_OE);
  endsequence
  a_pin_never_high: assert property (SYS_RST_PIN_OUT == 1'b0)
    else $error("reset pin driven high");
  a_oe_core_excl: assert property (CORE_RST_N |-> !SYS_RST_PIN_OE)
    else $error("pin pulled while core runs");
  a_pin_resets_core: assert property (pin_held_low |-> !CORE_RST_N)
    else $error("pin low did not reset core");
  a_por_length: assert property (CORE_RST_N |-> cyc >= 16'(POR_CYCLES))
    else $error("power-on reset too short");
  a_fb_pull_len: assert property (fb_pull_end |-> run == 16'(FBRST_CYCLES))
    else $error("fieldbus reset pull wrong length");
  a_clk_decode: assert property (OSC_SCHMITT_SEL |-> CLK_OUT_EN)
    else $error("schmitt mode without clock out");
  a_strap_hold: assert property (CORE_RST_N && $past(CORE_RST_N, 2) |->
    $stable(CLK_OUT_EN) && $stable(OSC_SCHMITT_SEL))
    else $error("strap decode moved while running");
  a_err_force: assert property ($rose(ERR_LED_FORCED) |-> $past(EEPROM_LOAD_ERR, 2))
    else $error("error indicator forced without eeprom error");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
    else $error("read data outside answer cycle");
endmodule
bind rsm_top rsm_chk #(.POR_CYCLES(POR_CYCLES), .FBRST_CYCLES(FBRST_CYCLES)) i_chk (.*);
`default_nettype wire

// ### tb/rsm_host_model.sv
/*
  rsm_host_model: external reset source and board clock strap.
  assumes a pull-up on the reset pin and open-drain drive by the device.
*/
`timescale 1ns/1ps
`default_nettype none
module rsm_host_model
  import rsm_pkg::*;
(
  // reset source
  input wire logic ext_low,
  input wire logic dev_oe,
  output logic pin,
  // clock strap
  input wire logic daisy,
  input wire logic [1:0] osc_sel,
  output logic [1:0] osc
);
  // pull-up wins unless someone sinks the line
  assign pin = !(ext_low || dev_oe);
  // a chained clock must enter through the schmitt input
  assign osc = daisy ? OSC_HIGH : osc_sel;
endmodule
`default_nettype wire

// ### tb/tb.sv
/*
  tb: self-checking bench for rsm_top with host model and checker.
  assumes shortened reset counts of 8 and 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %0h want %0h", $time, (a), (b)); end end
module tb;
  import rsm_pkg::*;
  logic clk, rst_n, wr, rd, wake, eep_err, ext_low, daisy, pin_out, pin_oe, core_n;
  logic clk_en, sch, irq, irq_oe, ferr;
  logic [7:0] addr, straps, last_s;
  logic [31:0] wdata, rdata, d;
  logic [1:0] core_irq, osc_sel;
  wire logic pin;
  wire logic [1:0] osc;
  wire logic [2:0] wk, wk_oe;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  rsm_top #(.POR_CYCLES(8), .FBRST_CYCLES(4)) i_dut (.REF_CLK(clk), .RST_N(rst_n),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SYS_RST_PIN_IN(pin),
    .SYS_RST_PIN_OUT(pin_out), .SYS_RST_PIN_OE(pin_oe), .CORE_RST_N(core_n),
    .STRAP_PINS(straps), .OSC_INPUT_MODE_STRAP(osc), .CLK_OUT_EN(clk_en),
    .OSC_SCHMITT_SEL(sch), .WAKE_DETECT(wake), .EEPROM_LOAD_ERR(eep_err),
    .CORE_IRQ(core_irq), .HOST_IRQ_OUT(irq), .HOST_IRQ_OE(irq_oe),
    .WAKE_EVENT_OUT(wk[0]), .WAKE_EVENT_OE(wk_oe[0]), .ERROR_INDICATOR_LED(wk[1]),
    .ERROR_INDICATOR_LED_OE(wk_oe[1]), .WAKE_GPIO_OUT(wk[2]), .WAKE_GPIO_OE(wk_oe[2]),
    .ERR_LED_FORCED(ferr));
  rsm_host_model i_host (.ext_low(ext_low), .dev_oe(pin_oe), .pin(pin), .daisy(daisy),
    .osc_sel(osc_sel), .osc(osc));
  function automatic logic [31:0] exp_strap(input logic [7:0] s, input logic [1:0] c);
    return {16'h0000, 4'h2, c, 2'h0, s};
  endfunction
  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one idle cycle after each strobe keeps every strobe a single cycle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) v = rdata;
  endtask
  task automatic wait_core(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (core_n !== 1'b1 && k < 100);
    @(posedge clk);
  endtask
  task automatic chk_cap(input logic [7:0] s, input logic [1:0] c);
    logic [31:0] v;
    rd_reg(ADR_STRAP, v);
    `CHK(v, exp_strap(s, c))
    rd_reg(ADR_IRQ_CFG, v);
    `CHK(v[IRQ_OD_BIT], s[0])
    rd_reg(ADR_WAKE_CFG, v);
    `CHK(v[WK_OD_BIT], s[1])
    `CHK({clk_en, sch}, {c != OSC_LOW, c == OSC_HIGH})
  endtask
  task automatic pin_reset(input logic [1:0] c, input logic dz);
    last_s = 8'($urandom);
    straps <= last_s;
    osc_sel <= c;
    daisy <= dz;
    ext_low <= 1'b1;
    idle(6);
    `CHK(core_n, 1'b0)
    ext_low <= 1'b0;
    wait_core(n);
    chk_cap(last_s, dz ? OSC_HIGH : c);
  endtask
  task automatic pulse_wake;
    wake <= 1'b1;
    idle(6);
    wake <= 1'b0;
    idle(1);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    void'($urandom(86));
    {rst_n, wr, rd, wake, eep_err, ext_low, daisy} = 7'h00;
    {addr, wdata, core_irq} = '0;
    osc_sel = OSC_MID;
    last_s = 8'($urandom);
    straps = last_s;
    idle(4);
    `CHK({pin_oe, core_n}, 2'h2)
    rst_n <= 1'b1;
    wait_core(n);
    `CHK(n >= 8 && n <= 12, 1'b1)
    chk_cap(last_s, OSC_MID);
    pin_reset(OSC_LOW, 1'b0);
    pin_reset(OSC_MID, 1'b0);
    pin_reset(OSC_LOW, 1'b1);
    // straps move while running; read-only and unmapped places
    straps <= ~last_s;
    wr_reg(ADR_STRAP, 32'h0000_0000);
    idle(4);
    chk_cap(last_s, OSC_HIGH);
    rd_reg(8'h20, d);
    `CHK(d, 32'h0000_0000)
    wr_reg(ADR_INT_CLR, 32'h0000_000F);
    wr_reg(ADR_INT_EN, 32'h0000_000F);
    wr_reg(ADR_IRQ_CFG, 32'h0000_0001);
    wr_reg(ADR_EVENT, 32'h0000_0001);
    idle(3);
    `CHK({irq, irq_oe}, 2'h3)
    wr_reg(ADR_IRQ_CFG, 32'h0000_0000);
    idle(3);
    `CHK({irq, irq_oe}, 2'h1)
    wr_reg(ADR_INT_CLR, 32'h0000_000F);
    wr_reg(ADR_IRQ_CFG, 32'h0000_0003);
    idle(3);
    `CHK(irq_oe, 1'b0)
    for (int s = 1; s < 3; s++) begin
      core_irq <= 2'($urandom);
      wr_reg(ADR_IRQ_CFG, 32'(s << IRQ_SRC_LSB) | 32'h0000_0001);
      idle(2);
      `CHK(irq, core_irq[s-1])
    end
    for (int m = 0; m < 3; m++) begin
      wr_reg(ADR_WAKE_CFG, 32'(m << WK_MAP_LSB) | 32'h0000_0003);
      pulse_wake;
      `CHK({wk[m], wk_oe}, {1'b1, 3'(1 << m)})
      wr_reg(ADR_INT_CLR, 32'h0000_0001);
    end
    wr_reg(ADR_WAKE_CFG, 32'h0000_0005);
    pulse_wake;
    `CHK({wk[0], wk_oe[0]}, 2'h1)
    wr_reg(ADR_INT_CLR, 32'h0000_0001);
    idle(2);
    `CHK(wk_oe[0], 1'b0)
    wr_reg(ADR_WAKE_CFG, 32'h0000_0000);
    pulse_wake;
    rd_reg(ADR_INT_STS, d);
    `CHK({d[EV_WAKE], wk_oe}, 4'h8)
    wr_reg(ADR_WAKE_CFG, 32'h0000_0013);
    eep_err <= 1'b1;
    idle(6);
    `CHK(ferr, 1'b1)
    eep_err <= 1'b0;
    rd_reg(ADR_INT_STS, d);
    `CHK(d[EV_EEP_ERR], 1'b1)
    last_s = 8'($urandom);
    straps <= last_s;
    daisy <= 1'b0;
    osc_sel <= OSC_MID;
    // a wrong byte must restart the key
    wr_reg(ADR_FB_RESET, 32'(FB_KEY0));
    wr_reg(ADR_FB_RESET, 32'h0000_0000);
    wr_reg(ADR_FB_RESET, 32'(FB_KEY2));
    idle(2);
    `CHK(core_n, 1'b1)
    wr_reg(ADR_FB_RESET, 32'(FB_KEY0));
    wr_reg(ADR_FB_RESET, 32'(FB_KEY1));
    wr_reg(ADR_FB_RESET, 32'(FB_KEY2));
    #1;
    `CHK({pin_oe, core_n, pin}, 3'h4)
    wait_core(n);
    chk_cap(last_s, OSC_MID);
    `CHK(ferr, 1'b0)
    wrap_up;
  end
endmodule
`default_nettype wire
